// *** hdl/pmcm_defs.svh ***
// offsets, field positions, reset values and timing counts of the clock manager
`ifndef PMCM_DEFS_SVH
`define PMCM_DEFS_SVH
`define PMCM_ADDR_PWR 8'h00
`define PMCM_ADDR_MODE 8'h04
`define PMCM_ADDR_SRC 8'h08
`define PMCM_ADDR_STAT 8'h0C
`define PMCM_ADDR_EVT 8'h10
`define PMCM_PWR_IDLE 0
`define PMCM_PWR_PDOWN 1
`define PMCM_MODE_SWB 5
`define PMCM_MODE_CD_LO 6
`define PMCM_SRC_WAKE_RC 1
`define PMCM_SRC_RC_IND 2
`define PMCM_SRC_XSEL 3
`define PMCM_SRC_XOFF 4
`define PMCM_STAT_XRDY 4
`define PMCM_CD_RESET 2'h1
`define PMCM_RST_CLKS 8
`define PMCM_WDT_RST_CLKS 512
`define PMCM_CLK_PERIOD_NS 10
`define PMCM_XTAL_WARM_NS 2000
`endif

// *** hdl/pmcm_pkg.sv ***
// types of the clock manager
package pmcm_pkg;
    typedef enum logic [1:0] {
        PMCM_RUN,
        PMCM_IDLE,
        PMCM_PDOWN
    } pmcm_mode_type;
endpackage

// *** hdl/pmcm_top.sv ***
// power mode and clock manager with ahb-lite register slave
`timescale 1ns/1ps
`include "pmcm_defs.svh"
module pmcm_top
    import pmcm_pkg::*;
#(
    parameter int XTAL_WARM_CYCLES =
        `PMCM_XTAL_WARM_NS / `PMCM_CLK_PERIOD_NS,
    parameter int WDT_RST_CYCLES = `PMCM_WDT_RST_CLKS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic reset_pin,
    input wire logic ext_irq_n,
    input wire logic ext_irq_en,
    input wire logic global_irq_en,
    input wire logic irq_wake,
    input wire logic irq_ack,
    input wire logic wdt_timeout,
    input wire logic wdt_clear,
    input wire logic wdt_rst_en,
    input wire logic por_reset,
    input wire logic ser_rx_line,
    input wire logic ser_rx_en,
    input wire logic ser_tx_write,
    input wire logic ser_busy,
    input wire logic instr_end,
    input wire logic crystal_stable,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic cycle_strobe,
    output logic cpu_reset,
    output logic skip_next_instr,
    output logic addr_latch_strobe,
    output logic prog_fetch_strobe,
    output logic port_hold,
    output logic osc_xtal_on,
    output logic osc_use_rc
);
    localparam int CD_RST_CYCLES = `PMCM_RST_CLKS;

    initial begin
        if (XTAL_WARM_CYCLES < 1 || XTAL_WARM_CYCLES > 65535)
            $error("pmcm_top: XTAL_WARM_CYCLES out of range");
        if (WDT_RST_CYCLES < 1 || WDT_RST_CYCLES > 65535)
            $error("pmcm_top: WDT_RST_CYCLES out of range");
    end

    // clocks per machine cycle for a divide code
    function automatic logic [10:0] cd_clocks(input logic [1:0] cd);
        case (cd)
            2'h2: cd_clocks = 11'h040;
            2'h3: cd_clocks = 11'h400;
            default: cd_clocks = 11'h004;
        endcase
    endfunction

    // three-stage synchronisers for pins
    logic [2:0] rst_sync;
    logic [2:0] irq_sync;
    logic [2:0] rx_sync;
    logic rst_lvl;
    logic irq_lvl;
    logic rx_lvl;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 3'h0;
            irq_sync <= 3'h7;
            rx_sync <= 3'h7;
        end else begin
            rst_sync <= {rst_sync[1:0], reset_pin};
            irq_sync <= {irq_sync[1:0], ext_irq_n};
            rx_sync <= {rx_sync[1:0], ser_rx_line};
        end
    end
    // a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_lvl <= 1'b0;
            irq_lvl <= 1'b1;
            rx_lvl <= 1'b1;
        end else begin
            if (rst_sync[1] == rst_sync[2])
                rst_lvl <= rst_sync[2];
            if (irq_sync[1] == irq_sync[2])
                irq_lvl <= irq_sync[2];
            if (rx_sync[1] == rx_sync[2])
                rx_lvl <= rx_sync[2];
        end
    end

    // reset pin qualifier: eight clocks high make a valid reset
    logic [3:0] rst_cnt;
    wire pin_reset = rst_lvl && (rst_cnt >= 4'(CD_RST_CYCLES - 1));
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rst_cnt <= 4'h0;
        else if (!rst_lvl)
            rst_cnt <= 4'h0;
        else if (rst_cnt != 4'hF)
            rst_cnt <= rst_cnt + 4'h1;
    end

    // watchdog reset follows timeout unless cleared; stopped in power down
    pmcm_mode_type mode;
    logic [15:0] wdt_cnt;
    logic wdt_armed;
    wire wdt_run = wdt_armed && (mode != PMCM_PDOWN);
    wire wdt_fire = wdt_run && (wdt_cnt == 16'(WDT_RST_CYCLES - 1));
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_armed <= 1'b0;
            wdt_cnt <= 16'h0000;
        end else if (wdt_clear || wdt_fire) begin
            wdt_armed <= 1'b0;
            wdt_cnt <= 16'h0000;
        end else if (wdt_run) begin
            wdt_cnt <= wdt_cnt + 16'h0001;
        end else if (wdt_timeout && wdt_rst_en) begin
            wdt_armed <= 1'b1;
        end
    end

    // any system reset source; watchdog is frozen in power down
    wire sys_reset = pin_reset || wdt_fire || por_reset;

    // ahb-lite address phase capture
    logic wr_pend;
    logic rd_pend;
    logic [7:0] ph_addr;
    wire ahb_go = hsel && htrans[1] && hready;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            wr_pend <= ahb_go && hwrite;
            rd_pend <= ahb_go && !hwrite;
            ph_addr <= haddr[7:0];
        end
    end
    wire wr_pwr = wr_pend && (ph_addr == `PMCM_ADDR_PWR);
    wire wr_mode = wr_pend && (ph_addr == `PMCM_ADDR_MODE);
    wire wr_src = wr_pend && (ph_addr == `PMCM_ADDR_SRC);
    wire wr_evt = wr_pend && (ph_addr == `PMCM_ADDR_EVT);

    // control state, software-visible except cd_act and wake_rc_hold
    logic idle_bit;
    logic pdown_bit;
    logic switchback_en;
    logic [1:0] cd_req;
    logic [1:0] cd_act;
    logic osc_source_sel;
    logic rc_active_ind;
    logic crystal_amp_off;
    logic crystal_ready_flag;
    logic rc_wake_sel;
    logic wake_rc_hold;

    // switchback triggers: start edge, buffer write or interrupt acknowledge
    logic rx_prev;
    wire rx_start = ser_rx_en && rx_prev && !rx_lvl;
    wire ext_sb = irq_ack && ext_irq_en && global_irq_en;
    wire sb_fire = switchback_en && (rx_start || ser_tx_write || ext_sb);
    wire cd_lock = switchback_en && ser_busy;
    wire cd_wr_ok = wr_mode && !cd_lock && (hwdata[7:6] != 2'h0);
    wire pd_wake = (mode == PMCM_PDOWN) && !irq_lvl
        && ext_irq_en && global_irq_en;
    wire idle_wake = (mode == PMCM_IDLE) && (irq_wake || wdt_timeout);
    // crystal selection refused until warm
    wire xsel_ok = hwdata[`PMCM_SRC_XSEL] && crystal_ready_flag;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rx_prev <= 1'b1;
        else
            rx_prev <= rx_lvl;
    end

    // power control bits; wake clears them, set by write otherwise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_bit <= 1'b0;
            pdown_bit <= 1'b0;
        end else if (sys_reset || idle_wake || pd_wake) begin
            idle_bit <= 1'b0;
            pdown_bit <= 1'b0;
        end else if (wr_pwr) begin
            idle_bit <= hwdata[`PMCM_PWR_IDLE];
            pdown_bit <= hwdata[`PMCM_PWR_PDOWN];
        end
    end

    // idle or power-down entry only at instruction end, so the setter completes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            mode <= PMCM_RUN;
        else if (sys_reset || idle_wake || pd_wake)
            mode <= PMCM_RUN;
        else if (mode == PMCM_RUN && instr_end && pdown_bit)
            mode <= PMCM_PDOWN;
        else if (mode == PMCM_RUN && instr_end && idle_bit)
            mode <= PMCM_IDLE;
    end

    // divide request and delayed activation
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            switchback_en <= 1'b0;
            cd_req <= `PMCM_CD_RESET;
        end else if (sys_reset) begin
            switchback_en <= 1'b0;
            cd_req <= `PMCM_CD_RESET;
        end else begin
            if (wr_mode)
                switchback_en <= hwdata[`PMCM_MODE_SWB];
            if (sb_fire)
                cd_req <= `PMCM_CD_RESET;
            else if (cd_wr_ok)
                cd_req <= hwdata[7:6];
        end
    end
    // switchback and reset act at once; other changes wait for instruction end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            cd_act <= `PMCM_CD_RESET;
        else if (sys_reset || sb_fire)
            cd_act <= `PMCM_CD_RESET;
        else if (instr_end)
            cd_act <= cd_req;
    end

    // oscillator source control
    logic [15:0] warm_cnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_source_sel <= 1'b1;
            crystal_amp_off <= 1'b0;
            rc_wake_sel <= 1'b0;
        end else if (sys_reset) begin
            osc_source_sel <= 1'b1;
            crystal_amp_off <= 1'b0;
            rc_wake_sel <= 1'b0;
        end else if (wr_src) begin
            osc_source_sel <= xsel_ok
                || (osc_source_sel && hwdata[`PMCM_SRC_XSEL]);
            crystal_amp_off <= hwdata[`PMCM_SRC_XOFF];
            rc_wake_sel <= hwdata[`PMCM_SRC_WAKE_RC];
        end
    end
    // active source follows selection one instruction later
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rc_active_ind <= 1'b0;
        else if (pd_wake && rc_wake_sel)
            rc_active_ind <= 1'b1;
        else if (wake_rc_hold && crystal_ready_flag)
            rc_active_ind <= !osc_source_sel;
        else if (instr_end && !wake_rc_hold)
            rc_active_ind <= !osc_source_sel;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            wake_rc_hold <= 1'b0;
        else if (pd_wake && rc_wake_sel)
            wake_rc_hold <= 1'b1;
        else if (crystal_ready_flag || sys_reset)
            wake_rc_hold <= 1'b0;
    end
    // crystal warm-up; amplifier off or stopped clocks restart it
    wire xtal_run = !crystal_amp_off && (mode != PMCM_PDOWN);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_cnt <= 16'h0000;
            crystal_ready_flag <= 1'b0;
        end else if (!xtal_run) begin
            warm_cnt <= 16'h0000;
            crystal_ready_flag <= 1'b0;
        end else if (warm_cnt == 16'(XTAL_WARM_CYCLES - 1)) begin
            crystal_ready_flag <= crystal_stable;
        end else begin
            warm_cnt <= warm_cnt + 16'h0001;
        end
    end

    // machine cycle divider; idle peripherals run at quarter rate
    logic [10:0] div_cnt;
    wire [10:0] div_len = (mode == PMCM_IDLE) ? 11'h004
        : cd_clocks(cd_act);
    wire div_wrap = (div_cnt >= div_len - 11'h001);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            div_cnt <= 11'h000;
        else if (div_wrap || mode == PMCM_PDOWN)
            div_cnt <= 11'h000;
        else
            div_cnt <= div_cnt + 11'h001;
    end

    // pin and clock enable outputs, all registered
    wire run_tick = div_wrap && (mode != PMCM_PDOWN);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            cycle_strobe <= 1'b0;
            cpu_reset <= 1'b1;
            skip_next_instr <= 1'b0;
            addr_latch_strobe <= 1'b1;
            prog_fetch_strobe <= 1'b1;
            port_hold <= 1'b0;
            osc_xtal_on <= 1'b1;
            osc_use_rc <= 1'b0;
        end else begin
            core_clk_en <= (mode == PMCM_RUN);
            periph_clk_en <= (mode != PMCM_PDOWN);
            cycle_strobe <= run_tick;
            cpu_reset <= sys_reset;
            skip_next_instr <= sys_reset && (mode != PMCM_RUN);
            addr_latch_strobe <= (mode != PMCM_PDOWN);
            prog_fetch_strobe <= (mode != PMCM_PDOWN);
            port_hold <= (mode == PMCM_IDLE);
            osc_xtal_on <= xtal_run;
            osc_use_rc <= rc_active_ind;
        end
    end

    // read mux
    wire [31:0] rd_val =
        (ph_addr == `PMCM_ADDR_PWR) ? {30'h0, pdown_bit, idle_bit} :
        (ph_addr == `PMCM_ADDR_MODE) ?
            {24'h0, cd_req, switchback_en, 5'h00} :
        (ph_addr == `PMCM_ADDR_SRC) ? {27'h0, crystal_amp_off,
            osc_source_sel, rc_active_ind, rc_wake_sel, 1'b0} :
        (ph_addr == `PMCM_ADDR_STAT) ?
            {27'h0, crystal_ready_flag, 4'h0} :
        (ph_addr == `PMCM_ADDR_EVT) ? {30'h0, mode} : 32'h0;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= (ahb_go && !hwrite) ? 32'h0 : hrdata;
            hreadyout <= !(ahb_go && !hwrite) || rd_pend;
            hresp <= 1'b0;
            if (rd_pend)
                hrdata <= rd_val;
        end
    end
    logic unused;
    assign unused = ^{hsize, hwdata[31:8], wr_evt, haddr[31:8]};
endmodule // pmcm_top

// *** bench/pmcm_monitor.sv ***
// port assertions for the power mode and clock manager
`timescale 1ns/1ps
module pmcm_monitor (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reset_pin,
    input wire logic ext_irq_n,
    input wire logic ext_irq_en,
    input wire logic global_irq_en,
    input wire logic irq_wake,
    input wire logic core_clk_en,
    input wire logic periph_clk_en,
    input wire logic cycle_strobe,
    input wire logic cpu_reset,
    input wire logic skip_next_instr,
    input wire logic addr_latch_strobe,
    input wire logic prog_fetch_strobe,
    input wire logic port_hold
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // all clocks off outside a reset means power down
    wire logic pd = !periph_clk_en && !cpu_reset;

    property p_idle_clk; port_hold |-> !core_clk_en && periph_clk_en; endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("idle clocks");
    property p_idle_pin;
        port_hold |-> addr_latch_strobe && prog_fetch_strobe;
    endproperty
    a_idle_pin: assert property (p_idle_pin) else $error("idle strobes");
    property p_pd_pin; pd |-> !addr_latch_strobe && !prog_fetch_strobe; endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("pdown strobes");
    // pin seen high well past sync plus eight clocks
    property p_rst_pin;
        $rose(reset_pin) ##0 reset_pin[*8] ##1 reset_pin[*6] |-> cpu_reset;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset missed");
    // strobes just after any reset come four clocks apart
    property p_div4; $fell(cpu_reset) ##[0:8] cycle_strobe |-> ##4 cycle_strobe;
    endproperty
    a_div4: assert property (p_div4) else $error("divide not 4");
    property p_skip; skip_next_instr |-> cpu_reset || $past(cpu_reset); endproperty
    a_skip: assert property (p_skip) else $error("stray skip");
    property p_pd_wake;
        pd && !ext_irq_n && ext_irq_en && global_irq_en |-> ##[1:16] periph_clk_en;
    endproperty
    a_pd_wake: assert property (p_pd_wake) else $error("no irq wake");
    property p_idle_wake;
        port_hold && irq_wake |-> ##[1:4] !port_hold && core_clk_en;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("no wake");
    c_idle: cover property (port_hold);
    c_pd: cover property (pd);
    c_skip: cover property (skip_next_instr);
endmodule // pmcm_monitor

bind pmcm_top pmcm_monitor i_pmcm_monitor (.*);

// *** bench/pmcm_cpu_model.sv ***
// core stand-in that ends one instruction per machine cycle
`timescale 1ns/1ps
module pmcm_cpu_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cycle_strobe,
    input wire logic core_clk_en,
    input wire logic cpu_reset,
    output logic instr_end
);
    // a frozen or resetting core completes nothing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_end <= 1'b0;
        end else begin
            instr_end <= cycle_strobe && core_clk_en && !cpu_reset;
        end
    end
endmodule // pmcm_cpu_model

// *** bench/pmcm_top_tb.sv ***
// self-checking bench for the power mode and clock manager
`timescale 1ns/1ps
`include "pmcm_defs.svh"
module pmcm_top_tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic reset_pin = 1'b0, ext_irq_n = 1'b1, ext_irq_en = 1'b0;
    logic global_irq_en = 1'b0, irq_wake = 1'b0, irq_ack = 1'b0;
    logic wdt_timeout = 1'b0, wdt_rst_en = 1'b0, ser_rx_line = 1'b1;
    logic wdt_clear = 1'b0, crystal_stable = 1'b1;
    logic ser_rx_en = 1'b0, ser_tx_write = 1'b0, ser_busy = 1'b0;
    logic hreadyout, hresp, core_clk_en, periph_clk_en, cycle_strobe;
    logic cpu_reset, skip_next_instr, addr_latch_strobe, prog_fetch_strobe;
    logic port_hold, osc_xtal_on, osc_use_rc, instr_end;
    logic [1:0] dcode [5] = '{2'h2, 2'h1, 2'h3, 2'h1, 2'h0};
    logic [31:0] dexp [5] = '{32'h40, 32'h4, 32'h400, 32'h4, 32'h4};
    int mismatches = 0, check_count = 0, skips = 0, resets = 0, g;
    int rcs = 0;

    always #5 sys_clk = ~sys_clk;

    // short warm-up and watchdog counts keep the run brief
    pmcm_top #(.XTAL_WARM_CYCLES(4), .WDT_RST_CYCLES(8)) i_pmcm_top (
        .hready(hreadyout), .hsize(3'h2), .por_reset(1'b0), .*);
    pmcm_cpu_model i_pmcm_cpu_model (.*);

    // tally reset, skip and rc-source cycles for later checks
    always @(posedge sys_clk) begin
        skips <= skips + int'(skip_next_instr === 1'b1);
        resets <= resets + int'(cpu_reset === 1'b1);
        rcs <= rcs + int'(osc_use_rc === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one single transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // clocks from one machine cycle strobe to the next
    task automatic gap(output int n);
        n = 0;
        do @(posedge sys_clk); while (cycle_strobe !== 1'b1);
        do begin
            @(posedge sys_clk);
            n++;
        end while (cycle_strobe !== 1'b1);
    endtask

    task automatic final_report;
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rchk(`PMCM_ADDR_PWR, 32'h0);
        rchk(`PMCM_ADDR_MODE, 32'h40);
        rchk(`PMCM_ADDR_SRC, 32'h08);
        rchk(`PMCM_ADDR_EVT, 32'h0);
        rchk(8'h20, 32'h0);
        // every divide code, back through four between slow rates
        foreach (dcode[i]) begin
            bus(1'b1, `PMCM_ADDR_MODE, {24'h0, dcode[i], 6'h0});
            gap(g);
            gap(g);
            chk(g, dexp[i]);
        end
        // switchback on tx write, rx start edge and irq acknowledge
        ext_irq_en <= 1'b1;
        global_irq_en <= 1'b1;
        ser_rx_en <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, `PMCM_ADDR_MODE, 32'hA0);
            gap(g);
            gap(g);
            ser_tx_write <= (k == 0);
            ser_rx_line <= (k != 1);
            irq_ack <= (k == 2);
            @(posedge sys_clk);
            ser_tx_write <= 1'b0;
            irq_ack <= 1'b0;
            repeat (6) @(posedge sys_clk);
            ser_rx_line <= 1'b1;
            rchk(`PMCM_ADDR_MODE, 32'h60);
        end
        ser_busy <= 1'b1;
        bus(1'b1, `PMCM_ADDR_MODE, 32'hA0);
        rchk(`PMCM_ADDR_MODE, 32'h60);
        ser_busy <= 1'b0;
        // idle left by an enabled interrupt
        bus(1'b1, `PMCM_ADDR_PWR, 32'h1);
        repeat (10) @(posedge sys_clk);
        chk(port_hold, 1'b1);
        rchk(`PMCM_ADDR_EVT, 32'h1);
        irq_wake <= 1'b1;
        repeat (4) @(posedge sys_clk);
        irq_wake <= 1'b0;
        rchk(`PMCM_ADDR_PWR, 32'h0);
        // watchdog time-out wakes idle, reset follows later
        wdt_rst_en <= 1'b1;
        bus(1'b1, `PMCM_ADDR_PWR, 32'h1);
        repeat (10) @(posedge sys_clk);
        g = resets;
        wdt_timeout <= 1'b1;
        @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk({port_hold, resets == g}, 2'h1);
        repeat (8) @(posedge sys_clk);
        chk(resets > g, 1'b1);
        // a clear right after the time-out preempts the reset
        g = resets;
        wdt_timeout <= 1'b1;
        @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        wdt_clear <= 1'b1;
        @(posedge sys_clk);
        wdt_clear <= 1'b0;
        repeat (12) @(posedge sys_clk);
        chk(resets == g, 1'b1);
        wdt_rst_en <= 1'b0;
        repeat (20) @(posedge sys_clk);
        // short pin pulse ignored, long one resets out of idle
        bus(1'b1, `PMCM_ADDR_PWR, 32'h1);
        repeat (10) @(posedge sys_clk);
        g = resets;
        reset_pin <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reset_pin <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk({port_hold, resets == g}, 2'h3);
        g = skips;
        reset_pin <= 1'b1;
        repeat (14) @(posedge sys_clk);
        reset_pin <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk(skips > g, 1'b1);
        rchk(`PMCM_ADDR_PWR, 32'h0);
        // power down, woken by the interrupt pin, then by the reset pin
        ext_irq_en <= 1'b1;
        bus(1'b1, `PMCM_ADDR_PWR, 32'h2);
        repeat (10) @(posedge sys_clk);
        chk({addr_latch_strobe, prog_fetch_strobe, periph_clk_en}, 3'h0);
        ext_irq_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        ext_irq_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rchk(`PMCM_ADDR_PWR, 32'h0);
        bus(1'b1, `PMCM_ADDR_PWR, 32'h2);
        repeat (10) @(posedge sys_clk);
        reset_pin <= 1'b1;
        repeat (14) @(posedge sys_clk);
        reset_pin <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rchk(`PMCM_ADDR_PWR, 32'h0);
        chk({core_clk_en, addr_latch_strobe}, 2'h3);
        // rc with amp off; amp on again before crystal, refused until ready
        bus(1'b1, `PMCM_ADDR_SRC, 32'h10);
        repeat (10) @(posedge sys_clk);
        rchk(`PMCM_ADDR_SRC, 32'h14);
        chk({osc_xtal_on, osc_use_rc}, 2'h1);
        crystal_stable <= 1'b0;
        bus(1'b1, `PMCM_ADDR_SRC, 32'h08);
        rchk(`PMCM_ADDR_SRC, 32'h04);
        repeat (20) @(posedge sys_clk);
        rchk(`PMCM_ADDR_STAT, 32'h0);
        crystal_stable <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rchk(`PMCM_ADDR_STAT, 32'h10);
        bus(1'b1, `PMCM_ADDR_SRC, 32'h08);
        repeat (10) @(posedge sys_clk);
        rchk(`PMCM_ADDR_SRC, 32'h08);
        chk(osc_use_rc, 1'b0);
        // rc wake from power down, then back on the crystal by itself
        bus(1'b1, `PMCM_ADDR_SRC, 32'h0A);
        g = rcs;
        bus(1'b1, `PMCM_ADDR_PWR, 32'h2);
        repeat (10) @(posedge sys_clk);
        ext_irq_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        ext_irq_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk(rcs > g, 1'b1);
        chk(osc_use_rc, 1'b0);
        rchk(`PMCM_ADDR_PWR, 32'h0);
        final_report;
    end

    // cut a hang short well past the expected run time
    initial begin
        #500000;
        mismatches++;
        final_report;
    end
endmodule // pmcm_top_tb
